// ### sbst_consts.vh
`ifndef SBST_CONSTS_VH
`define SBST_CONSTS_VH
// register lengths and high mode-select count to test-logic-reset
`define SBST_IR_LEN      3
`define SBST_ID_LEN      32
`define SBST_BND_LEN     109
`define SBST_TLR_ONES    5
// instruction codes
`define SBST_INS_EXTEST  3'h0
`define SBST_INS_IDCODE  3'h1
`define SBST_INS_SAMPLEZ 3'h2
`define SBST_INS_PRELOAD 3'h4
`define SBST_INS_BYPASS  3'h7
// capture pattern of the instruction register
`define SBST_IR_CAPTURE  3'h1
// identification code, arbitrary neutral value
`define SBST_IDCODE_VAL  32'h1234_5679
// tap state codes
`define SBST_ST_TLR  4'h0
`define SBST_ST_RTI  4'h1
`define SBST_ST_SDRS 4'h2
`define SBST_ST_CDR  4'h3
`define SBST_ST_SDR  4'h4
`define SBST_ST_E1DR 4'h5
`define SBST_ST_PDR  4'h6
`define SBST_ST_E2DR 4'h7
`define SBST_ST_UDR  4'h8
`define SBST_ST_SIRS 4'h9
`define SBST_ST_CIR  4'ha
`define SBST_ST_SIR  4'hb
`define SBST_ST_E1IR 4'hc
`define SBST_ST_PIR  4'hd
`define SBST_ST_E2IR 4'he
`define SBST_ST_UIR  4'hf
`endif

// ### sbst_tap_fsm.v
`timescale 1ns/1ps
`default_nettype none
`include "sbst_consts.vh"
module sbst_tap_fsm (
  input  wire       ref_clk,   // system clock
  input  wire       rst_n,     // asynchronous reset, active low
  input  wire       tck_rise,  // one-cycle pulse at test clock rising edge
  input  wire       tms_s,     // synchronised mode select
  output reg  [3:0] state_reg  // current tap state
);
  reg [3:0] state_next;

  // sixteen-state transition table
  always @* begin
    state_next = state_reg;
    case (state_reg)
      `SBST_ST_TLR:  state_next = tms_s ? `SBST_ST_TLR  : `SBST_ST_RTI;
      `SBST_ST_RTI:  state_next = tms_s ? `SBST_ST_SDRS : `SBST_ST_RTI;
      `SBST_ST_SDRS: state_next = tms_s ? `SBST_ST_SIRS : `SBST_ST_CDR;
      `SBST_ST_CDR:  state_next = tms_s ? `SBST_ST_E1DR : `SBST_ST_SDR;
      `SBST_ST_SDR:  state_next = tms_s ? `SBST_ST_E1DR : `SBST_ST_SDR;
      `SBST_ST_E1DR: state_next = tms_s ? `SBST_ST_UDR  : `SBST_ST_PDR;
      `SBST_ST_PDR:  state_next = tms_s ? `SBST_ST_E2DR : `SBST_ST_PDR;
      `SBST_ST_E2DR: state_next = tms_s ? `SBST_ST_UDR  : `SBST_ST_SDR;
      `SBST_ST_UDR:  state_next = tms_s ? `SBST_ST_SDRS : `SBST_ST_RTI;
      `SBST_ST_SIRS: state_next = tms_s ? `SBST_ST_TLR  : `SBST_ST_CIR;
      `SBST_ST_CIR:  state_next = tms_s ? `SBST_ST_E1IR : `SBST_ST_SIR;
      `SBST_ST_SIR:  state_next = tms_s ? `SBST_ST_E1IR : `SBST_ST_SIR;
      `SBST_ST_E1IR: state_next = tms_s ? `SBST_ST_UIR  : `SBST_ST_PIR;
      `SBST_ST_PIR:  state_next = tms_s ? `SBST_ST_E2IR : `SBST_ST_PIR;
      `SBST_ST_E2IR: state_next = tms_s ? `SBST_ST_UIR  : `SBST_ST_SIR;
      `SBST_ST_UIR:  state_next = tms_s ? `SBST_ST_SDRS : `SBST_ST_RTI;
      default:       state_next = `SBST_ST_TLR;
    endcase
  end

  // state steps only on a test clock rising edge
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= `SBST_ST_TLR;
    end else if (tck_rise) begin
      state_reg <= state_next;
    end
  end
endmodule
`default_nettype wire

// ### sbst_tap.v
// Behaviour
// - tms and tdi are sampled at each test clock rising edge.
// - tdo and its enable change only at test clock falling edges.
// - mode select alone steps the tap state machine.
// - serial path chosen from tap state and current instruction.
// - five high mode-select rising edges always reach test-logic-reset.
// - power-up reset puts the tap in test-logic-reset.
// - new instruction takes effect leaving update-ir toward idle or data states.
// - instruction shifts only while it sits on the serial path.
// - instruction preset to identification at power-up and in test-logic-reset.
// - one-bit bypass register selectable as serial path.
// - bypass passes data with a single stage of delay.
// - 32-bit identification register captures fixed code under identification.
// - identification register shifts during shift-dr.
// - boundary register captures pin ring values in capture-dr.
// - boundary register shifts during shift-dr.
// - several instructions select the boundary register.
// - each boundary bit maps to one fixed pin in exit order.
// - only a small instruction subset is supported; others act as bypass.
`timescale 1ns/1ps
`default_nettype none
`include "sbst_consts.vh"
module sbst_tap #(
  parameter BND_LEN = `SBST_BND_LEN, // boundary register length
  parameter IR_LEN  = `SBST_IR_LEN,  // instruction register length
  parameter ID_LEN  = `SBST_ID_LEN   // identification register length
) (
  input  wire               ref_clk,    // system clock, 100 MHz
  input  wire               rst_n,      // power-up reset, active low
  input  wire               tck,        // test clock pin
  input  wire               tms,        // test mode select pin
  input  wire               tdi,        // test data in pin
  input  wire [BND_LEN-1:0] ring_in,    // pin ring values, bit 0 = exit order bit 1
  output reg                tdo,        // test data out
  output reg                tdo_oe,     // tdo drive enable, high while shifting
  output reg  [BND_LEN-1:0] bnd_upd,    // boundary update latch toward the pins
  output reg                extest_on,  // high while extest instruction is active
  output reg  [3:0]         tap_state,  // current tap state
  output reg  [IR_LEN-1:0]  ins_active  // instruction in effect
);
  // synchronisers
  reg [2:0] tck_sync_reg;
  reg [1:0] tms_sync_reg;
  reg [1:0] tdi_sync_reg;
  wire      tck_rise;
  wire      tck_fall;
  wire      tms_s;
  wire      tdi_s;
  wire [3:0] st;

  reg [IR_LEN-1:0]  ir_shift_reg;
  reg [ID_LEN-1:0]  id_shift_reg;
  reg [BND_LEN-1:0] bnd_shift_reg;
  reg               byp_reg;
  reg               tdo_next;
  reg               oe_next;

  // true when the instruction selects the boundary register
  function sel_bnd;
    input [IR_LEN-1:0] ins;
    begin
      sel_bnd = (ins == `SBST_INS_EXTEST) || (ins == `SBST_INS_SAMPLEZ) ||
                (ins == `SBST_INS_PRELOAD);
    end
  endfunction

  // true for the bypass instruction and for instructions outside the supported set
  function is_byp;
    input [IR_LEN-1:0] ins;
    begin
      is_byp = !sel_bnd(ins) && (ins != `SBST_INS_IDCODE);
    end
  endfunction

  // two flip-flops on each pin, third tck stage for edge finding
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tck_sync_reg <= 3'h0;
      tms_sync_reg <= 2'h3;
      tdi_sync_reg <= 2'h3;
    end else begin
      tck_sync_reg <= {tck_sync_reg[1:0], tck};
      tms_sync_reg <= {tms_sync_reg[0], tms};
      tdi_sync_reg <= {tdi_sync_reg[0], tdi};
    end
  end

  assign tck_rise = tck_sync_reg[1] & ~tck_sync_reg[2];
  assign tck_fall = ~tck_sync_reg[1] & tck_sync_reg[2];
  assign tms_s    = tms_sync_reg[1];
  assign tdi_s    = tdi_sync_reg[1];

  sbst_tap_fsm u_fsm (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .tck_rise  (tck_rise),
    .tms_s     (tms_s),
    .state_reg (st)
  );

  // instruction shift and update
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ir_shift_reg <= `SBST_IR_CAPTURE;
      ins_active   <= `SBST_INS_IDCODE;
    end else if (st == `SBST_ST_TLR) begin
      // preset as soon as test-logic-reset is entered, not one tck later
      ins_active <= `SBST_INS_IDCODE;
    end else if (tck_rise) begin
      if (st == `SBST_ST_CIR) begin
        ir_shift_reg <= `SBST_IR_CAPTURE;
      end else if (st == `SBST_ST_SIR) begin
        ir_shift_reg <= {tdi_s, ir_shift_reg[IR_LEN-1:1]};
      end else if (st == `SBST_ST_UIR) begin
        ins_active <= ir_shift_reg;
      end
    end
  end

  // data registers: capture and shift
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      byp_reg       <= 1'b0;
      id_shift_reg  <= {ID_LEN{1'b0}};
      bnd_shift_reg <= {BND_LEN{1'b0}};
    end else if (tck_rise) begin
      if (st == `SBST_ST_CDR) begin
        byp_reg <= 1'b0;
        if (ins_active == `SBST_INS_IDCODE) begin
          id_shift_reg <= `SBST_IDCODE_VAL;
        end
        if (sel_bnd(ins_active)) begin
          bnd_shift_reg <= ring_in;
        end
      end else if (st == `SBST_ST_SDR) begin
        byp_reg <= tdi_s;
        if (ins_active == `SBST_INS_IDCODE) begin
          id_shift_reg <= {tdi_s, id_shift_reg[ID_LEN-1:1]};
        end
        if (sel_bnd(ins_active)) begin
          bnd_shift_reg <= {tdi_s, bnd_shift_reg[BND_LEN-1:1]};
        end
      end
    end
  end

  // boundary update latch and mode flag
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bnd_upd   <= {BND_LEN{1'b0}};
      extest_on <= 1'b0;
    end else begin
      extest_on <= (ins_active == `SBST_INS_EXTEST);
      if (tck_fall && st == `SBST_ST_UDR && sel_bnd(ins_active)) begin
        bnd_upd <= bnd_shift_reg;
      end
    end
  end

  // serial output selection by state and instruction
  always @* begin
    tdo_next = 1'b0;
    oe_next  = 1'b0;
    if (st == `SBST_ST_SIR) begin
      tdo_next = ir_shift_reg[0];
      oe_next  = 1'b1;
    end else if (st == `SBST_ST_SDR) begin
      oe_next = 1'b1;
      if (ins_active == `SBST_INS_IDCODE) begin
        tdo_next = id_shift_reg[0];
      end else if (sel_bnd(ins_active)) begin
        tdo_next = bnd_shift_reg[0];
      end else if (is_byp(ins_active)) begin
        tdo_next = byp_reg;
      end
    end
  end

  // outputs move at the falling test clock edge only
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tdo       <= 1'b0;
      tdo_oe    <= 1'b0;
      tap_state <= `SBST_ST_TLR;
    end else if (tck_fall) begin
      tdo       <= tdo_next;
      tdo_oe    <= oe_next;
      tap_state <= st;
    end
  end
endmodule
`default_nettype wire

// ### sbst_jtag_host.sv
`timescale 1ns/1ps
`default_nettype none
module sbst_jtag_host (
  input  wire logic ref_clk, // system clock
  input  wire logic tdo,     // serial out of the port
  output var  logic tck,     // test clock, still between steps
  output var  logic tms,     // mode select
  output var  logic tdi      // serial data
);
  // idle levels: clock low, mode select high
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // one 90 ns test clock period; tdo taken just before the rise
  task automatic step(input logic m, d, output logic q);
    @(posedge ref_clk);
    #1;
    tms = m;
    tdi = d;
    repeat (4) @(posedge ref_clk);
    #1;
    q = tdo;
    tck = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    tck = 1'b0;
  endtask
  // idle to shift, n bits lsb first, back to idle
  task automatic scan(input logic ir, input int n, input logic [127:0] din,
                      output logic [127:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b0, q);
    if (ir) step(1'b1, 1'b0, q);
    repeat (2) step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
endmodule
`default_nettype wire

// ### sbst_tap_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module sbst_tap_monitor #(
  parameter BND_LEN = 109 // boundary length
) (
  input wire logic               ref_clk,   // clock
  input wire logic               rst_n,     // reset
  input wire logic               tck,       // test clock
  input wire logic               tms,       // mode select
  input wire logic               tdo,       // serial out
  input wire logic               tdo_oe,    // out enable
  input wire logic [BND_LEN-1:0] bnd_upd,   // update latch
  input wire logic               extest_on, // extest flag
  input wire logic [3:0]         tap_state, // tap state
  input wire logic [2:0]         ins_active // instruction
);
  logic       tck_reg;  // sampled test clock
  logic [2:0] ones_reg; // high mode-select rises in a row
  wire        rise = tck & ~tck_reg;
  wire        shf = tap_state == 4'h4 || tap_state == 4'hb;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // count rises with mode select high
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tck_reg  <= 1'b0;
      ones_reg <= 3'h0;
    end else begin
      tck_reg <= tck;
      if (rise) ones_reg <= tms ? ones_reg + 3'h1 : 3'h0;
    end
  end
  a_out_on_fall: assert property (tck [*3] |=> $stable(tdo) && $stable(tdo_oe)
    && $stable(tap_state)) else $error("output moved while tck high");
  a_five_ones: assert property (rise && tms && ones_reg == 3'h4 |-> ##[1:12] !tap_state)
    else $error("no reset after five high tms");
  a_tlr_idcode: assert property (tap_state == 4'h0 [*3] |-> ins_active == 3'h1)
    else $error("instruction not preset");
  a_oe_shift: assert property (shf [*2] |-> tdo_oe)
    else $error("tdo not enabled in shift");
  a_idle_quiet: assert property (!shf [*2] |-> !tdo_oe && !tdo)
    else $error("tdo active outside shift");
  a_extest_flag: assert property ($stable(ins_active) [*2] |-> extest_on == !ins_active)
    else $error("extest flag wrong");
  a_ins_update: assert property ($changed(ins_active) |-> tap_state inside {4'hf, 4'h0, 4'h9})
    else $error("instruction moved off update");
  a_bnd_update: assert property ($changed(bnd_upd) |-> ins_active inside {3'h0, 3'h2, 3'h4}
    && (tap_state == 4'h8 || $past(tap_state) == 4'h8)) else $error("latch moved off update");
endmodule
bind sbst_tap sbst_tap_monitor #(.BND_LEN(BND_LEN)) mon_u (.ref_clk, .rst_n, .tck, .tms, .tdo,
  .tdo_oe, .bnd_upd, .extest_on, .tap_state, .ins_active);
`default_nettype wire

// ### sbst_tap_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sbst_consts.vh"
module sbst_tap_tb_top;
  typedef struct {
    logic [2:0]   ins;
    int           len;
    logic [127:0] cap;
  } sbst_row_t;
  localparam logic [108:0] RING = {1'b1, {9{12'ha5c}}};
  localparam logic [127:0] PAT = {8{16'h9c36}};
  logic         ref_clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         tck, tms, tdi, tdo, tdo_oe, extest_on;
  logic [108:0] bnd_upd;
  logic [3:0]   tap_state;
  logic [2:0]   ins_active;
  logic [127:0] pat, dout;
  int           n_errors = 0;
  int           compares = 0;
  // instruction, selected length, captured value
  sbst_row_t    rows [8] = '{'{3'h0, 109, RING}, '{3'h1, 32, `SBST_IDCODE_VAL},
    '{3'h2, 109, RING}, '{3'h3, 1, 0}, '{3'h4, 109, RING}, '{3'h5, 1, 0}, '{3'h6, 1, 0},
    '{3'h7, 1, 0}};
  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;
  sbst_jtag_host host_u (.ref_clk, .tdo, .tck, .tms, .tdi);
  sbst_tap dut_u (.ref_clk, .rst_n, .tck, .tms, .tdi, .ring_in(RING), .tdo, .tdo_oe,
    .bnd_upd, .extest_on, .tap_state, .ins_active);
  task automatic check(input string what, input logic [127:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    #400us;
    n_errors++;
    wrap_up();
  end
  // main sequence
  initial begin
    logic q;
    repeat (10) @(posedge ref_clk);
    #1;
    check("reset state", tap_state, `SBST_ST_TLR);
    check("reset ins", ins_active, `SBST_INS_IDCODE);
    rst_n = 1'b1;
    repeat (3) @(posedge ref_clk);
    host_u.step(1'b0, 1'b0, q);
    foreach (rows[i]) begin
      pat = {PAT[127:125] ^ rows[i].ins, PAT[124:0]};
      host_u.scan(1'b1, 3, rows[i].ins, dout);
      check("ir capture", dout[2:0], `SBST_IR_CAPTURE);
      check("ins active", ins_active, rows[i].ins);
      check("extest flag", extest_on, rows[i].ins == 3'h0);
      host_u.scan(1'b0, 128, pat, dout);
      check("dr stream", dout, (pat << rows[i].len) | rows[i].cap);
      if (rows[i].len == 109) check("update latch", bnd_upd, pat[127:19]);
      $display("row %0d done", i);
    end
    // five high mode-select rises from inside shift-dr
    host_u.step(1'b1, 1'b0, q);
    repeat (2) host_u.step(1'b0, 1'b0, q);
    repeat (5) host_u.step(1'b1, 1'b0, q);
    repeat (6) @(posedge ref_clk);
    check("tlr state", tap_state, `SBST_ST_TLR);
    check("tlr ins", ins_active, `SBST_INS_IDCODE);
    $display("tlr test done");
    // reset in mid-run with extest loaded
    host_u.step(1'b0, 1'b0, q);
    host_u.scan(1'b1, 3, `SBST_INS_EXTEST, dout);
    rst_n = 1'b0;
    #20;
    check("mid state", tap_state, `SBST_ST_TLR);
    check("mid flag", extest_on, 1'b0);
    check("mid ins", ins_active, `SBST_INS_IDCODE);
    rst_n = 1'b1;
    repeat (3) @(posedge ref_clk);
    host_u.step(1'b0, 1'b0, q);
    repeat (4) @(posedge ref_clk);
    check("post reset state", tap_state, `SBST_ST_RTI);
    $display("reset test done");
    wrap_up();
  end
endmodule
`default_nettype wire
